// *** hdl/fdcc_cmd.sv ***
// command phase decoder: positioning, sensing, dump and invalid codes
`timescale 1ns/1ps
`include "fdcc_consts.svh"
module fdcc_cmd #(
  parameter int STEP_CYCLES = (`FDCC_STEP_TIME_NS + `FDCC_CLK_NS - 1) / `FDCC_CLK_NS
)(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire fdcc_pkg::fdcc_byte_t   wr,
  output logic                        wr_ready,
  output logic                        rd_valid,
  output logic [7:0]                  rd_data,
  input  wire logic                   rd_ack,
  output logic                        busy,
  output logic                        irq,
  input  wire fdcc_pkg::fdcc_cfg_t    cfg,
  input  wire fdcc_pkg::fdcc_drv_in_t drv_in,
  output fdcc_pkg::fdcc_drv_out_t     drv_out
);
  localparam int PULSE_CYCLES = (`FDCC_PULSE_TIME_NS + `FDCC_CLK_NS - 1) / `FDCC_CLK_NS;

  // ***************************************
  // declarations
  // ***************************************
  fdcc_pkg::fdcc_drv_in_t sync1, sync2;           // pin synchroniser
  fdcc_pkg::fdcc_state_t  state, next_state;      // sequencer
  fdcc_pkg::fdcc_kind_t   kind, next_kind;        // result block
  logic [7:0]  cmd, next_cmd;                     // command byte held
  logic [1:0]  pleft, next_pleft;                 // parameters to come
  logic [1:0]  drive, next_drive;                 // drive select
  logic        head, next_head;                   // head select
  logic [7:0]  target, next_target;               // cylinder to reach
  logic        recal, next_recal;                 // exec is recalibrate
  logic [7:0]  steps, next_steps;                 // steps issued
  logic [31:0] timer, next_timer;                 // step interval
  logic        step_on, next_step_on;             // step pulse
  logic        dir, next_dir;                     // step direction
  logic        int_pend, next_int_pend;           // completion interrupt
  logic [7:0]  int_st0, next_int_st0;             // stored status zero
  logic [1:0]  int_drv, next_int_drv;             // drive that finished
  logic [3:0]  res_cnt, next_res_cnt;             // result length
  logic [3:0]  idx, next_idx;                     // load index
  logic [3:0]  rd_ptr, next_rd_ptr;               // read index
  logic [7:0]  present_cylinder_number [4];                           // present cylinder numbers
  logic [7:0]  next_pcn [4];
  logic        pcn_we;                            // update selected cylinder
  logic [7:0]  pcn_wval;
  logic [7:0]  cur_pcn;                           // cylinder of selected drive
  logic        mem_we;
  logic [7:0]  res_byte;                          // byte being queued
  logic        accept;                            // byte taken from host
  logic        is_pos, is_inv, two_par, sel_byte; // decode flags
  logic [8:0]  rel_sum;

  // ***************************************
  // pin synchroniser
  // ***************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= drv_in;
      sync2 <= sync1;
    end
  end

  // ***************************************
  // decode
  // ***************************************
  // host may only move a byte while ready is high
  assign wr_ready = (state == fdcc_pkg::S_IDLE) || (state == fdcc_pkg::S_PARAM);
  assign accept   = wr.valid && wr_ready;
  assign rd_valid = (state == fdcc_pkg::S_RESULT);
  assign busy     = (state != fdcc_pkg::S_IDLE);
  assign irq      = int_pend;
  assign drv_out  = '{step: step_on, dir: dir, sel: drive, head: head};
  assign cur_pcn  = present_cylinder_number[drive];
  assign is_pos   = (wr.data == `FDCC_CMD_RECAL) || (wr.data == `FDCC_CMD_SEEK)
                 || (wr.data == `FDCC_CMD_SENSE_DRV)
                 || ((wr.data & `FDCC_REL_MASK) == `FDCC_CMD_REL_SEEK);
  assign is_inv   = !is_pos && (wr.data != `FDCC_CMD_SENSE_INT)
                 && (wr.data != `FDCC_CMD_DUMP);
  assign two_par  = (cmd == `FDCC_CMD_SEEK)
                 || ((cmd & `FDCC_REL_MASK) == `FDCC_CMD_REL_SEEK);
  assign sel_byte = (pleft == 2'd2) || !two_par;
  assign rel_sum  = {1'b0, cur_pcn} + {1'b0, wr.data};

  // result byte selected by block kind and index
  always_comb begin
    res_byte = `FDCC_ST0_INVALID;
    case (kind)
      fdcc_pkg::K_INT:  res_byte = (idx == 4'd0) ? int_st0 : present_cylinder_number[int_drv];
      fdcc_pkg::K_ST3:  res_byte = {1'b0, sync2.wprot, sync2.ready, sync2.track0,
                                    sync2.two_side, head, drive};
      fdcc_pkg::K_DUMP: begin
        case (idx)
          4'd4:    res_byte = {cfg.step_rate_time, cfg.head_unload_time};
          4'd5:    res_byte = {cfg.head_load_time, cfg.non_dma_flag};
          4'd6:    res_byte = cfg.sector_count;
          4'd7:    res_byte = cfg.lock_perp;
          4'd8:    res_byte = cfg.cfg_opts;
          4'd9:    res_byte = cfg.precomp_start_track;
          default: res_byte = present_cylinder_number[idx[1:0]];
        endcase
      end
      default:          res_byte = `FDCC_ST0_INVALID;
    endcase
  end

  // ***************************************
  // sequencer next state
  // ***************************************
  always_comb begin
    next_state = state;  next_kind = kind;  next_cmd = cmd;  next_pleft = pleft;
    next_drive = drive;  next_head = head;  next_target = target;
    next_recal = recal;  next_steps = steps;  next_timer = timer;
    next_step_on = step_on;  next_dir = dir;  next_int_pend = int_pend;
    next_int_st0 = int_st0;  next_int_drv = int_drv;  next_res_cnt = res_cnt;
    next_idx = idx;  next_rd_ptr = rd_ptr;
    pcn_we = 1'b0;  pcn_wval = cur_pcn;  mem_we = 1'b0;
    case (state)
      fdcc_pkg::S_IDLE: begin
        if (accept) begin
          next_cmd = wr.data;
          next_idx = 4'd0;
          if (is_pos) begin
            next_state = fdcc_pkg::S_PARAM;
            next_pleft = ((wr.data == `FDCC_CMD_SEEK) || wr.data[7]) ? 2'd2 : 2'd1;
          end else if (wr.data == `FDCC_CMD_SENSE_INT && int_pend) begin
            next_state    = fdcc_pkg::S_LOAD;
            next_kind     = fdcc_pkg::K_INT;
            next_res_cnt  = `FDCC_LEN_INT;
            next_int_pend = 1'b0;
          end else if (wr.data == `FDCC_CMD_DUMP) begin
            next_state   = fdcc_pkg::S_LOAD;
            next_kind    = fdcc_pkg::K_DUMP;
            next_res_cnt = `FDCC_LEN_DUMP;
          end else begin
            // undefined code, or sense interrupt with nothing pending
            next_state   = fdcc_pkg::S_LOAD;
            next_kind    = fdcc_pkg::K_INV;
            next_res_cnt = `FDCC_LEN_ONE;
          end
        end
      end
      fdcc_pkg::S_PARAM: begin
        if (accept) begin
          next_pleft = pleft - 2'd1;
          if (sel_byte) begin
            next_drive = wr.data[1:0];
            next_head  = wr.data[2];
          end
          if (pleft == 2'd1) begin
            if (cmd == `FDCC_CMD_SENSE_DRV) begin
              next_state   = fdcc_pkg::S_LOAD;
              next_kind    = fdcc_pkg::K_ST3;
              next_res_cnt = `FDCC_LEN_ONE;
              next_timer   = `FDCC_SETTLE_CYC;
            end else begin
              next_state   = fdcc_pkg::S_EXEC;
              // track zero of the new drive is only seen after the settle time
              next_timer   = `FDCC_SETTLE_CYC;
              next_steps   = 8'd0;
              next_recal   = (cmd == `FDCC_CMD_RECAL);
              if (cmd == `FDCC_CMD_SEEK) begin
                next_target = wr.data;
              end else if (cmd[6]) begin
                next_target = rel_sum[8] ? 8'hff : rel_sum[7:0];
              end else begin
                next_target = (cur_pcn > wr.data) ? cur_pcn - wr.data : 8'h00;
              end
            end
          end
        end
      end
      fdcc_pkg::S_EXEC: begin
        if (timer != 32'd0) begin
          next_timer = timer - 32'd1;
          if (timer == 32'(STEP_CYCLES - PULSE_CYCLES)) begin
            next_step_on = 1'b0;
          end
        end else if ((recal && sync2.track0) || (!recal && cur_pcn == target)) begin
          next_state    = fdcc_pkg::S_IDLE;
          next_int_pend = 1'b1;
          next_int_st0  = `FDCC_ST0_SEEK_END | {5'h00, head, drive};
          next_int_drv  = drive;
          pcn_we        = recal;
          pcn_wval      = 8'h00;
        end else if (recal && steps == `FDCC_RECAL_MAX) begin
          next_state    = fdcc_pkg::S_IDLE;
          next_int_pend = 1'b1;
          next_int_st0  = `FDCC_ST0_EQUIP_ERR | {5'h00, head, drive};
          next_int_drv  = drive;
        end else begin
          // one step, then wait a whole step interval
          next_step_on = 1'b1;
          next_dir     = !recal && (target > cur_pcn);
          next_steps   = steps + 8'd1;
          next_timer   = 32'(STEP_CYCLES - 1);
          pcn_we       = 1'b1;
          if (!recal && target > cur_pcn) begin
            pcn_wval = cur_pcn + 8'd1;
          end else if (cur_pcn != 8'h00) begin
            pcn_wval = cur_pcn - 8'd1;
          end
        end
      end
      fdcc_pkg::S_LOAD: begin
        if (timer != 32'd0) begin
          // wait until the synchronised pins show the newly selected drive
          next_timer = timer - 32'd1;
        end else if (idx == res_cnt) begin
          next_state  = fdcc_pkg::S_RESULT;
          next_rd_ptr = 4'd0;
        end else begin
          mem_we   = 1'b1;
          next_idx = idx + 4'd1;
        end
      end
      fdcc_pkg::S_RESULT: begin
        if (rd_ack) begin
          if (rd_ptr == res_cnt - 4'd1) begin
            next_state = fdcc_pkg::S_IDLE;
          end else begin
            next_rd_ptr = rd_ptr + 4'd1;
          end
        end
      end
      default: next_state = fdcc_pkg::S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= fdcc_pkg::S_IDLE;  kind <= fdcc_pkg::K_INV;  cmd <= 8'h00;
      pleft <= 2'd0;  drive <= 2'd0;  head <= 1'b0;  target <= 8'h00;
      recal <= 1'b0;  steps <= 8'h00;  timer <= 32'd0;  step_on <= 1'b0;
      dir <= 1'b0;  int_pend <= 1'b0;  int_st0 <= 8'h00;  int_drv <= 2'd0;
      res_cnt <= 4'd0;  idx <= 4'd0;  rd_ptr <= 4'd0;
    end else begin
      state <= next_state;  kind <= next_kind;  cmd <= next_cmd;
      pleft <= next_pleft;  drive <= next_drive;  head <= next_head;
      target <= next_target;  recal <= next_recal;  steps <= next_steps;
      timer <= next_timer;  step_on <= next_step_on;  dir <= next_dir;
      int_pend <= next_int_pend;  int_st0 <= next_int_st0;
      int_drv <= next_int_drv;  res_cnt <= next_res_cnt;  idx <= next_idx;
      rd_ptr <= next_rd_ptr;
    end
  end

  // ***************************************
  // per drive present cylinder number
  // ***************************************
  for (genvar i = 0; i < 4; i++) begin : g_pcn
    assign next_pcn[i] = (pcn_we && drive == 2'(i)) ? pcn_wval : present_cylinder_number[i];
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        present_cylinder_number[i] <= 8'h00;
      end else begin
        present_cylinder_number[i] <= next_pcn[i];
      end
    end
  end

  // result queue
  fdcc_result_mem #(.WIDTH(8), .DEPTH(16), .AW(4)) u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (mem_we),
    .waddr (idx),
    .wdata (res_byte),
    .raddr (next_rd_ptr),
    .rdata (rd_data)
  );

  // ***************************************
  // checks
  // ***************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take(logic [7:0] c);
    accept && state == fdcc_pkg::S_IDLE && wr.data == c;
  endsequence
  sequence s_exec_due;
    state == fdcc_pkg::S_EXEC && timer == 32'd0;
  endsequence
  property p_recal_dir;
    state == fdcc_pkg::S_EXEC && recal && step_on |-> !drv_out.dir;
  endproperty
  a_recal_dir: assert property (p_recal_dir) else $error("recal step inward");
  property p_recal_irq;
    s_exec_due ##0 (recal && sync2.track0) |=> irq && !busy && present_cylinder_number[drive] == 8'h00;
  endproperty
  a_recal_irq: assert property (p_recal_irq) else $error("recal end wrong");
  property p_seek_hit;
    s_exec_due ##0 (!recal && cur_pcn == target) |=> irq && !busy && int_st0[5];
  endproperty
  a_seek_hit: assert property (p_seek_hit) else $error("seek end wrong");
  property p_sis_two;
    s_take(`FDCC_CMD_SENSE_INT) ##0 int_pend |=> res_cnt == 4'd2 ##3
      (rd_valid && rd_data == int_st0);
  endproperty
  a_sis_two: assert property (p_sis_two) else $error("sense int result");
  property p_sis_noparam;
    s_take(`FDCC_CMD_SENSE_INT) |=> state == fdcc_pkg::S_LOAD;
  endproperty
  a_sis_noparam: assert property (p_sis_noparam) else $error("sense int param");
  property p_dump_ten;
    s_take(`FDCC_CMD_DUMP) |=> res_cnt == 4'd10 ##11 (rd_valid && rd_data == present_cylinder_number[0]);
  endproperty
  a_dump_ten: assert property (p_dump_ten) else $error("dump result wrong");
  property p_sds_one;
    accept && state == fdcc_pkg::S_PARAM && pleft == 2'd1 && cmd == `FDCC_CMD_SENSE_DRV
      |=> res_cnt == 4'd1 && kind == fdcc_pkg::K_ST3;
  endproperty
  a_sds_one: assert property (p_sds_one) else $error("drive status length");
  property p_inv;
    accept && state == fdcc_pkg::S_IDLE && is_inv |=> ##2
      (rd_valid && rd_data == 8'h80 && res_cnt == 4'd1);
  endproperty
  a_inv: assert property (p_inv) else $error("invalid code result");
  property p_inv_idle;
    rd_valid && rd_ack && rd_ptr == res_cnt - 4'd1 |=> wr_ready && !busy;
  endproperty
  a_inv_idle: assert property (p_inv_idle) else $error("no standby after result");
endmodule // fdcc_cmd

// *** hdl/fdcc_result_mem.sv ***
// result byte queue storage with registered read data
`timescale 1ns/1ps
module fdcc_result_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];  // storage words

  // ***************************************
  // storage, one cleared entry per word
  // ***************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem[i] <= '0;
      end else if (we && waddr == AW'(i)) begin
        mem[i] <= wdata;
      end
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // fdcc_result_mem

// *** pkg/fdcc_consts.svh ***
// constants of the floppy command decoder: codes, status values, timing
// Overview of operation
// - recalibrate steps out to track zero, then interrupts
// - seek moves head to new cylinder number
// - sense interrupt returns status zero, then cylinder
// - code 08h is sense interrupt, no parameters
// - register dump returns ten bytes in order
// - sense drive status returns one status byte three
// - unknown code returns single status byte 80h
// - after invalid code, back to standby
`ifndef FDCC_CONSTS_SVH
`define FDCC_CONSTS_SVH
// command codes
`define FDCC_CMD_SENSE_DRV 8'h04
`define FDCC_CMD_RECAL     8'h07
`define FDCC_CMD_SENSE_INT 8'h08
`define FDCC_CMD_DUMP      8'h0e
`define FDCC_CMD_SEEK      8'h0f
`define FDCC_REL_MASK      8'hbf
`define FDCC_CMD_REL_SEEK  8'h8f
// status byte zero values (drive and head bits are or-ed into seek end and equipment error)
`define FDCC_ST0_INVALID   8'h80
`define FDCC_ST0_SEEK_END  8'h20
`define FDCC_ST0_EQUIP_ERR 8'h70
// result lengths
`define FDCC_LEN_INT       4'd2
`define FDCC_LEN_DUMP      4'd10
`define FDCC_LEN_ONE       4'd1
// timing: clock period, least step interval, least step pulse width
`define FDCC_CLK_NS        25
`define FDCC_STEP_TIME_NS  3000000
`define FDCC_PULSE_TIME_NS 1000
// outward steps tried before recalibrate gives up
`define FDCC_RECAL_MAX     8'd80
// cycles a new drive select needs to pass the pin synchroniser
`define FDCC_SETTLE_CYC    32'd2
`endif

// *** pkg/fdcc_pkg.sv ***
// types shared by the floppy command decoder
package fdcc_pkg;
  // command sequencer states
  typedef enum logic [2:0] {S_IDLE, S_PARAM, S_EXEC, S_LOAD, S_RESULT} fdcc_state_t;
  // which result block is being queued
  typedef enum logic [1:0] {K_INT, K_DUMP, K_ST3, K_INV} fdcc_kind_t;
  // host byte write
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fdcc_byte_t;
  // drive pins into the block, active high
  typedef struct packed {
    logic track0;
    logic wprot;
    logic ready;
    logic two_side;
  } fdcc_drv_in_t;
  // drive pins out of the block, active high
  typedef struct packed {
    logic       step;
    logic       dir;     // 1 inward, 0 outward
    logic [1:0] sel;
    logic       head;
  } fdcc_drv_out_t;
  // settings reported by register dump
  typedef struct packed {
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic       non_dma_flag;
    logic [7:0] sector_count;
    logic [7:0] lock_perp;
    logic [7:0] cfg_opts;
    logic [7:0] precomp_start_track;
  } fdcc_cfg_t;
endpackage

// *** verif/fdcc_drive_model.sv ***
// drive side model: head position per drive follows the step pulses
`timescale 1ns/1ps
module fdcc_drive_model #(
  parameter int START = 5 // cylinder each head rests on at power-up
)(
  input  wire logic                    clk,
  input  wire fdcc_pkg::fdcc_drv_out_t drv_out,
  input  wire logic                    wprot,
  input  wire logic                    ready,
  input  wire logic                    two_side,
  output fdcc_pkg::fdcc_drv_in_t       drv_in
);
  // ****************************************
  // head mechanics
  // ****************************************
  logic [7:0] pos [4]; // head position of each drive, kept over reset
  logic       step_d;  // step level of the previous cycle
  initial begin
    step_d = 1'b0;
    for (int i = 0; i < 4; i++) pos[i] = 8'(START);
  end
  // one cylinder per rising step, the stop at track zero blocks outward moves
  always @(posedge clk) begin
    step_d <= drv_out.step;
    if (drv_out.step && !step_d) begin
      if (drv_out.dir) pos[drv_out.sel] <= pos[drv_out.sel] + 8'h01;
      else if (pos[drv_out.sel] != 8'h00) pos[drv_out.sel] <= pos[drv_out.sel] - 8'h01;
    end
  end
  // track zero sensor of the selected drive, other pins from the bench
  assign drv_in = {pos[drv_out.sel] == 8'h00, wprot, ready, two_side};
endmodule // fdcc_drive_model

// *** verif/floppy_ctrl_command_set_test.sv ***
// self-checking bench of the floppy command decoder
`timescale 1ns/1ps
module floppy_ctrl_command_set_test;
  localparam int STEPS = 60; // shortened step interval
  logic                    clk, rst_b, wr_ready, rd_valid, rd_ack, busy, irq;
  logic                    wprot, ready, two_side;
  logic [7:0]              rd_data;
  logic [7:0]              present_cylinder_number [4]; // expected cylinder of each drive
  logic [7:0]              dx [10]; // expected dump bytes
  fdcc_pkg::fdcc_byte_t    wr;
  fdcc_pkg::fdcc_cfg_t     cfg;
  fdcc_pkg::fdcc_drv_in_t  drv_in;
  fdcc_pkg::fdcc_drv_out_t drv_out;
  int                      n_errors, check_count, seed;
  logic [1:0]              d;
  logic                    h;
  logic [7:0]              c;
  fdcc_cmd #(.STEP_CYCLES(STEPS)) i_dut (
    .clk(clk), .rst_b(rst_b), .wr(wr), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ack(rd_ack), .busy(busy), .irq(irq), .cfg(cfg),
    .drv_in(drv_in), .drv_out(drv_out));
  fdcc_drive_model i_drv (.clk(clk), .drv_out(drv_out), .wprot(wprot), .ready(ready),
    .two_side(two_side), .drv_in(drv_in));
  // ****************************************
  // compare and bus tasks, all entered and left at a falling edge
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // host write, only once the port shows it can take a byte
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (wr_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk1(wr_ready, 1'b1, "write port ready");
    wr.valid = 1'b1;
    wr.data = b;
    @(negedge clk);
    wr.valid = 1'b0;
    @(negedge clk); // one idle cycle between two bytes
  endtask
  // host read of one result byte, then pop it
  task automatic get(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk1(rd_valid, 1'b1, "result present");
    chk8(rd_data, exp, what);
    rd_ack = 1'b1;
    @(negedge clk);
    rd_ack = 1'b0;
    @(negedge clk); // one idle cycle between two pops
  endtask
  // wait for a positioning command to end, then collect its status
  task automatic done_pos(input logic [1:0] dd, input logic hh, input logic [7:0] cyl);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk1(busy, 1'b0, "positioning finished");
    chk1(irq, 1'b1, "completion interrupt");
    chk8({5'h00, drv_out.head, drv_out.sel}, {5'h00, hh, dd}, "drive select pins");
    chk8(i_drv.pos[dd], cyl, "head position");
    put(8'h08);
    get(8'h20 | {5'h00, hh, dd}, "status zero");
    get(cyl, "present cylinder");
    chk1(irq, 1'b0, "interrupt taken");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang short well after the expected run length
  initial begin
    #(25ns * 80000);
    n_errors++;
    end_of_test();
  end
  initial begin
    seed = 79;
    n_errors = 0;
    check_count = 0;
    wr = '0;
    rd_ack = 1'b0;
    wprot = 1'b0;
    ready = 1'b1;
    two_side = 1'b1;
    cfg = 48'({$random(seed), $random(seed)});
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk1(wr_ready, 1'b1, "ready after reset");
    chk1(busy, 1'b0, "busy after reset");
    chk1(irq, 1'b0, "irq after reset");
    // sense interrupt with nothing pending answers like an unknown code
    put(8'h08);
    get(8'h80, "no pending interrupt");
    // corner codes first, then random codes that match no command
    for (int i = 0; i < 8; i++) begin
      case (i)
        0: c = 8'h10;
        1: c = 8'h03;
        2: c = 8'hff;
        3: c = 8'h00;
        default: begin
          c = 8'h04;
          while (c inside {8'h04, 8'h07, 8'h08, 8'h0e, 8'h0f, 8'h8f, 8'hcf}) c = 8'($random(seed));
        end
      endcase
      put(c);
      get(8'h80, "invalid code status");
      chk1(rd_valid, 1'b0, "single result byte");
      chk1(wr_ready, 1'b1, "back in standby");
    end
    // recalibrate every drive from its resting cylinder
    for (int i = 0; i < 4; i++) begin
      h = 1'($random(seed));
      put(8'h07);
      put({5'h00, h, 2'(i)});
      chk1(busy, 1'b1, "recalibrate running");
      done_pos(2'(i), h, 8'h00);
      present_cylinder_number[i] = 8'h00;
    end
    // seeks, the first one to the cylinder already reached
    for (int i = 0; i < 5; i++) begin
      d = 2'($random(seed));
      h = 1'($random(seed));
      c = (i == 0) ? present_cylinder_number[d] : 8'($random(seed)) & 8'h0f;
      put(8'h0f);
      put({5'h00, h, d});
      put(c);
      done_pos(d, h, c);
      present_cylinder_number[d] = c;
    end
    // relative seek outward past track zero, then inward
    for (int i = 0; i < 2; i++) begin
      d = 2'($random(seed));
      c = (i == 0) ? 8'h14 : 8'h03;
      put((i == 0) ? 8'h8f : 8'hcf);
      put({5'h00, 1'b0, d});
      put(c);
      present_cylinder_number[d] = (i == 0) ? ((present_cylinder_number[d] > c) ? present_cylinder_number[d] - c : 8'h00) : present_cylinder_number[d] + c;
      done_pos(d, 1'b0, present_cylinder_number[d]);
    end
    // drive status with random drive pins
    for (int i = 0; i < 4; i++) begin
      d = 2'(i);
      h = 1'($random(seed));
      {wprot, ready, two_side} = 3'($random(seed));
      put(8'h04);
      put({5'h00, h, d});
      get({1'b0, wprot, ready, present_cylinder_number[d] == 8'h00, two_side, h, d}, "drive status");
      chk1(rd_valid, 1'b0, "one status byte");
    end
    // register dump in its fixed order
    for (int i = 0; i < 4; i++) dx[i] = present_cylinder_number[i];
    dx[4] = {cfg.step_rate_time, cfg.head_unload_time};
    dx[5] = {cfg.head_load_time, cfg.non_dma_flag};
    dx[6] = cfg.sector_count;
    dx[7] = cfg.lock_perp;
    dx[8] = cfg.cfg_opts;
    dx[9] = cfg.precomp_start_track;
    put(8'h0e);
    for (int i = 0; i < 10; i++) get(dx[i], "dump byte");
    chk1(rd_valid, 1'b0, "ten dump bytes only");
    end_of_test();
  end
endmodule // floppy_ctrl_command_set_test
